// ==== rtl/dmb_pkg.sv ====
// Package: constants for the data-memory bank addressing block
package dmb_pkg;
   // ----------------------------------------
   // Address geometry
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam int MEM_BYTES = 4096;
   localparam int BANK_W = 4;
   localparam int OFFS_W = 8;
   localparam int NUM_BANKS = 16;
   localparam int BANK_BYTES = 256;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] ACCESS_SPLIT_EXT = 8'h60;
   localparam logic [7:0] BANK_PTR_RESET = 8'h00;
   localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
   // ----------------------------------------
   // Pipeline phases, one per clock
   // ----------------------------------------
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} dmb_phase_e;
   typedef enum logic [1:0] {OP_NONE, OP_BANKED, OP_FULL, OP_LOAD_BANK} dmb_op_e;
endpackage : dmb_pkg

// ==== rtl/dmb_addr_map.sv ====
// Address former: banked, access map or full address
`timescale 1ns/1ps
module dmb_addr_map (
   input wire logic [3:0] bank_i,
   input wire logic [7:0] offset_i,
   input wire logic access_sel_i,
   input wire logic ext_set_i,
   input wire logic [11:0] full_i,
   input wire logic full_mode_i,
   output logic [11:0] addr_o
);
   logic [7:0] split;
   always_comb begin
      split = ext_set_i ? dmb_pkg::ACCESS_SPLIT_EXT : dmb_pkg::ACCESS_SPLIT;
      if (full_mode_i) begin
         addr_o = full_i;
      end else if (access_sel_i) begin
         addr_o = {bank_i, offset_i};
      end else if (offset_i < split) begin
         addr_o = {dmb_pkg::ACCESS_LOW_BANK, offset_i};
      end else begin
         addr_o = {dmb_pkg::ACCESS_HIGH_BANK, offset_i};
      end
   end
endmodule : dmb_addr_map

// ==== rtl/dmb_bank_ram.sv ====
// One bank of data RAM, with optional second port for the USB engine
`timescale 1ns/1ps
module dmb_bank_ram #(
   parameter int DEPTH = 256
) (
   input wire logic clk_i,
   input wire logic [7:0] addr_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic [7:0] usb_addr_i,
   input wire logic usb_we_i,
   input wire logic [7:0] usb_wdata_i,
   output logic [7:0] usb_rdata_o
);
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      if (usb_we_i) begin
         mem[usb_addr_i] <= usb_wdata_i;
      end
   end
   assign rdata_o = mem[addr_i];
   assign usb_rdata_o = mem[usb_addr_i];
endmodule : dmb_bank_ram

// ==== rtl/dmb_top.sv ====
// Data-memory bank addressing and access for the 8-bit core
// Notes on behaviour
// - Data addresses are 12 bits, 4096 bytes
// - Sixteen banks of 256 bytes, upper nibble
// - Unimplemented locations read as zero
// - Bank pointer high bits, instruction low byte
// - Bank pointer upper nibble reads zero
// - Load-bank-literal writes bank pointer
// - Unimplemented bank: writes dropped, reads zero
// - Flags updated as if access succeeded
// - Full-address move ignores bank pointer
// - Access map: 00-5F bank0, 60-FF bank15
// - Select bit one banked, zero access map
// - Access map needs no bank update
// - Extended set keeps the same access map (split also 60)
// - Lone second word runs as no-op
// - In-sequence second word is operand data
// - USB off: dual banks are plain RAM
// - USB on: dual banks shared with engine
// - Operand read Q2, destination write Q4
`timescale 1ns/1ps
module dmb_top #(
   parameter logic [15:0] BANK_IMPL = 16'h800F,
   parameter logic [15:0] USB_BANKS = 16'h0006
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic skipped_i,
   input wire logic [1:0] op_i,
   input wire logic access_sel_i,
   input wire logic [7:0] offset_i,
   input wire logic [7:0] literal_i,
   input wire logic [11:0] src_full_i,
   input wire logic write_en_i,
   input wire logic [7:0] wdata_i,
   input wire logic ext_set_i,
   input wire logic usb_en_i,
   input wire logic [11:0] usb_addr_i,
   input wire logic usb_we_i,
   input wire logic [7:0] usb_wdata_i,
   output logic [7:0] usb_rdata_o,
   output logic [1:0] phase_o,
   output logic [7:0] bank_pointer_o,
   output logic [11:0] addr_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic flags_upd_o,
   output logic is_nop_o,
   output logic [11:0] dest_full_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      dmb_pkg::dmb_phase_e phase;
      logic [3:0] bank;
      logic busy;
      logic wait_second;
      dmb_pkg::dmb_op_e op;
      logic [11:0] addr;
      logic [11:0] dest;
      logic [7:0] rdata;
      logic rvalid;
      logic flags;
      logic nop;
      logic [7:0] usb_rdata;
   } dmb_state_s;
   dmb_state_s st_r;
   dmb_state_s st_nxt;

   logic [11:0] map_addr;
   logic [11:0] acc_addr;
   logic [7:0] ram_rd [dmb_pkg::NUM_BANKS];
   logic [7:0] usb_rd [dmb_pkg::NUM_BANKS];
   logic [3:0] acc_bank;
   logic is_second_word;
   logic do_write;
   logic [3:0] usb_bank;
   logic usb_ok;

   dmb_addr_map u_map (
      .bank_i(st_r.bank),
      .offset_i(offset_i),
      .access_sel_i(access_sel_i),
      .ext_set_i(ext_set_i),
      .full_i(src_full_i),
      .full_mode_i(dmb_pkg::dmb_op_e'(op_i) == dmb_pkg::OP_FULL),
      .addr_o(map_addr)
   );

   // ----------------------------------------
   // Banks
   // ----------------------------------------
   // Access address is latched at the start of an instruction and used in Q2 and Q4
   assign acc_addr = st_r.addr;
   assign acc_bank = acc_addr[11:8];
   assign do_write = st_r.busy && st_r.phase == dmb_pkg::PH_Q4 && st_r.op != dmb_pkg::OP_NONE
                     && st_r.op != dmb_pkg::OP_LOAD_BANK && write_en_i;
   assign usb_bank = usb_addr_i[11:8];
   // Engine only reaches the dual banks while USB is on
   assign usb_ok = usb_en_i && USB_BANKS[usb_bank];

   genvar g;
   generate
      for (g = 0; g < dmb_pkg::NUM_BANKS; g++) begin : g_bank
         if (BANK_IMPL[g]) begin : g_impl
            dmb_bank_ram #(.DEPTH(dmb_pkg::BANK_BYTES)) u_ram (
               .clk_i(clk_i),
               .addr_i(acc_addr[7:0]),
               .we_i(do_write && acc_bank == 4'(g)),
               .wdata_i(wdata_i),
               .rdata_o(ram_rd[g]),
               .usb_addr_i(usb_addr_i[7:0]),
               .usb_we_i(usb_we_i && usb_ok && usb_bank == 4'(g)),
               .usb_wdata_i(usb_wdata_i),
               .usb_rdata_o(usb_rd[g])
            );
         end else begin : g_none
            assign ram_rd[g] = 8'h00;
            assign usb_rd[g] = 8'h00;
         end
      end
   endgenerate

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   assign is_second_word = instr_i[15:12] == dmb_pkg::SECOND_WORD_TAG;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.flags = 1'b0;
      st_nxt.nop = 1'b0;
      st_nxt.usb_rdata = usb_ok ? usb_rd[usb_bank] : 8'h00;
      unique case (st_r.phase)
         dmb_pkg::PH_Q1: st_nxt.phase = dmb_pkg::PH_Q2;
         dmb_pkg::PH_Q2: st_nxt.phase = dmb_pkg::PH_Q3;
         dmb_pkg::PH_Q3: st_nxt.phase = dmb_pkg::PH_Q4;
         dmb_pkg::PH_Q4: st_nxt.phase = dmb_pkg::PH_Q1;
      endcase
      if (st_r.phase == dmb_pkg::PH_Q1 && instr_valid_i) begin
         if (st_r.wait_second && !skipped_i) begin
            // Second word of a full move carries the destination address
            st_nxt.dest = instr_i[11:0];
            st_nxt.wait_second = 1'b0;
            st_nxt.busy = 1'b1;
            st_nxt.op = dmb_pkg::OP_FULL;
         end else if (is_second_word) begin
            st_nxt.nop = 1'b1;
            st_nxt.busy = 1'b0;
            st_nxt.op = dmb_pkg::OP_NONE;
            st_nxt.wait_second = 1'b0;
         end else begin
            st_nxt.op = dmb_pkg::dmb_op_e'(op_i);
            st_nxt.addr = map_addr;
            st_nxt.busy = 1'b1;
            st_nxt.wait_second = dmb_pkg::dmb_op_e'(op_i) == dmb_pkg::OP_FULL;
            if (dmb_pkg::dmb_op_e'(op_i) == dmb_pkg::OP_FULL) begin
               st_nxt.busy = 1'b0;
            end
            if (dmb_pkg::dmb_op_e'(op_i) == dmb_pkg::OP_LOAD_BANK) begin
               st_nxt.bank = literal_i[3:0];
            end
         end
      end else if (st_r.phase == dmb_pkg::PH_Q1) begin
         st_nxt.busy = 1'b0;
      end
      if (st_r.busy && st_r.phase == dmb_pkg::PH_Q2 && st_r.op != dmb_pkg::OP_LOAD_BANK) begin
         st_nxt.rdata = BANK_IMPL[acc_bank] ? ram_rd[acc_bank] : 8'h00;
         st_nxt.rvalid = 1'b1;
      end
      if (do_write) begin
         st_nxt.flags = 1'b1;
      end
      if (st_r.busy && st_r.phase == dmb_pkg::PH_Q4 && st_r.op == dmb_pkg::OP_FULL) begin
         // Full move: destination becomes the access address after Q4; the Q4 write itself goes to the source address
         st_nxt.addr = st_r.dest;
         st_nxt.op = dmb_pkg::OP_BANKED;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
         st_r.bank <= dmb_pkg::BANK_PTR_RESET[3:0];
      end else begin
         st_r <= st_nxt;
      end
   end

   assign phase_o = st_r.phase;
   assign bank_pointer_o = {4'h0, st_r.bank};
   assign addr_o = st_r.addr;
   assign rdata_o = st_r.rdata;
   assign rdata_valid_o = st_r.rvalid;
   assign flags_upd_o = st_r.flags;
   assign is_nop_o = st_r.nop;
   assign dest_full_o = st_r.dest;
   assign usb_rdata_o = st_r.usb_rdata;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_upper_zero;
      @(posedge clk_i) disable iff (!rst_n_i) bank_pointer_o[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("bank upper nibble set");

   property p_load_bank;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd3 && !is_second_word && !st_r.wait_second)
         |=> bank_pointer_o[3:0] == $past(literal_i[3:0]);
   endproperty
   a_load_bank: assert property (p_load_bank) else $error("bank load missed");

   property p_unimpl_zero;
      @(posedge clk_i) disable iff (!rst_n_i)
         (rdata_valid_o && !BANK_IMPL[addr_o[11:8]]) |-> rdata_o == 8'h00;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");

   property p_lone_nop;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && is_second_word && !st_r.wait_second)
         |=> is_nop_o ##1 !rdata_valid_o;
   endproperty
   a_lone_nop: assert property (p_lone_nop) else $error("lone second word not a no-op");

   property p_read_q2;
      @(posedge clk_i) disable iff (!rst_n_i) rdata_valid_o |-> phase_o == 2'd2;
   endproperty
   a_read_q2: assert property (p_read_q2) else $error("read outside Q2");

   property p_flag_q4;
      @(posedge clk_i) disable iff (!rst_n_i) flags_upd_o |-> phase_o == 2'd0;
   endproperty
   a_flag_q4: assert property (p_flag_q4) else $error("flag update outside Q4");

   property p_banked;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd1 && access_sel_i && !is_second_word
          && !st_r.wait_second) |=> addr_o == {$past(bank_pointer_o[3:0]), $past(offset_i)};
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong");

   property p_access;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd1 && !access_sel_i && !is_second_word
          && !st_r.wait_second)
         |=> addr_o[11:8] == ($past(offset_i) < 8'h60 ? 4'h0 : 4'hF);
   endproperty
   a_access: assert property (p_access) else $error("access map wrong");

   property p_second;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && st_r.wait_second && !skipped_i)
         |=> dest_full_o == $past(instr_i[11:0]) && !is_nop_o;
   endproperty
   a_second: assert property (p_second) else $error("second word not consumed");

   // ----------------------------------------
   // Checks on full moves, pulses and the engine port
   // ----------------------------------------
   property p_full_src;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd2 && !is_second_word
          && !st_r.wait_second) |=> addr_o == $past(src_full_i);
   endproperty
   a_full_src: assert property (p_full_src) else $error("full move source wrong");

   property p_full_dest;
      @(posedge clk_i) disable iff (!rst_n_i)
         (st_r.busy && st_r.phase == dmb_pkg::PH_Q4 && st_r.op == dmb_pkg::OP_FULL)
         |=> addr_o == $past(dest_full_o);
   endproperty
   a_full_dest: assert property (p_full_dest) else $error("full move dest wrong");

   property p_flag_any_bank;
      @(posedge clk_i) disable iff (!rst_n_i)
         (st_r.busy && st_r.phase == dmb_pkg::PH_Q4 && st_r.op == dmb_pkg::OP_BANKED
          && write_en_i) |=> flags_upd_o;
   endproperty
   a_flag_any_bank: assert property (p_flag_any_bank) else $error("flag update missed");

   property p_flag_pulse;
      @(posedge clk_i) disable iff (!rst_n_i) flags_upd_o |=> !flags_upd_o;
   endproperty
   a_flag_pulse: assert property (p_flag_pulse) else $error("flag pulse too long");

   property p_rvalid_pulse;
      @(posedge clk_i) disable iff (!rst_n_i) rdata_valid_o |=> !rdata_valid_o;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read pulse too long");

   property p_one_cycle;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd1 && !is_second_word
          && !st_r.wait_second) |-> ##2 rdata_valid_o;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("operand not read in cycle");

   property p_offset_low;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd1 && !is_second_word
          && !st_r.wait_second) |=> addr_o[7:0] == $past(offset_i);
   endproperty
   a_offset_low: assert property (p_offset_low) else $error("offset byte wrong");

   property p_ext_map;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && op_i == 2'd1 && !access_sel_i && ext_set_i
          && !is_second_word && !st_r.wait_second)
         |=> addr_o[11:8] == ($past(offset_i) < dmb_pkg::ACCESS_SPLIT_EXT ? 4'h0 : 4'hF);
   endproperty
   a_ext_map: assert property (p_ext_map) else $error("extended map wrong");

   property p_skipped_nop;
      @(posedge clk_i) disable iff (!rst_n_i)
         (phase_o == 2'd0 && instr_valid_i && st_r.wait_second && skipped_i && is_second_word)
         |=> is_nop_o;
   endproperty
   a_skipped_nop: assert property (p_skipped_nop) else $error("skipped word executed");

   property p_nop_idle;
      @(posedge clk_i) disable iff (!rst_n_i) is_nop_o |-> !st_r.busy;
   endproperty
   a_nop_idle: assert property (p_nop_idle) else $error("no-op left an access busy");

   property p_usb_off;
      @(posedge clk_i) disable iff (!rst_n_i) !usb_en_i |=> usb_rdata_o == 8'h00;
   endproperty
   a_usb_off: assert property (p_usb_off) else $error("engine read while disabled");

   property p_usb_bank;
      @(posedge clk_i) disable iff (!rst_n_i)
         (usb_en_i && !USB_BANKS[usb_addr_i[11:8]]) |=> usb_rdata_o == 8'h00;
   endproperty
   a_usb_bank: assert property (p_usb_bank) else $error("engine read outside dual banks");

   // First edge after reset release still holds the reset phase, hence the guard
   property p_phase_step;
      @(posedge clk_i) disable iff (!rst_n_i)
         $past(rst_n_i) |-> phase_o == $past(phase_o) + 2'd1;
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
endmodule : dmb_top

// ==== sim/dmb_core_model.sv ====
// Core sequencer model: issues instructions in Q1, write strobe in Q4
`timescale 1ns/1ps
module dmb_core_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] phase_i,
   input wire logic issue_i,
   input wire logic wr_i,
   output logic instr_valid_o,
   output logic write_en_o
);
   logic wr_r;
   // Held off outside Q1 so no word is ever offered mid-cycle
   assign instr_valid_o = issue_i && (phase_i == 2'h0);
   assign write_en_o = wr_r && (phase_i == 2'h3);
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_r <= 1'b0;
      end else if (phase_i == 2'h0) begin
         wr_r <= instr_valid_o && wr_i;
      end
   end
endmodule : dmb_core_model

// ==== sim/data_memory_bank_addressing_bench.sv ====
// Self-checking bench for the data-memory bank addressing block
`timescale 1ns/1ps
module data_memory_bank_addressing_bench;
   localparam logic [15:0] IMPL = 16'h800F;
   localparam logic [15:0] DUAL = 16'h0006;
   logic clk_i, rst_n_i, issue, wr, ivld, skp, acc, wen, ext, usb_en, usb_we;
   logic rdv, flags, nop;
   logic [1:0] op, phase;
   logic [15:0] instr;
   logic [7:0] offs, lit, wdata, usb_wdata, usb_rdata, bp, rdata, got;
   logic [11:0] src, usb_addr, addr, dest;
   logic [7:0] mem [4096];
   bit known [4096];
   logic [3:0] cur_bp;
   int fails, checks, nrd, nfl, nnop;
   logic [31:0] r;
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   dmb_core_model i_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .phase_i(phase), .issue_i(issue),
      .wr_i(wr), .instr_valid_o(ivld), .write_en_o(wen));
   dmb_top #(.BANK_IMPL(IMPL), .USB_BANKS(DUAL)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .instr_valid_i(ivld), .instr_i(instr), .skipped_i(skp), .op_i(op), .access_sel_i(acc),
      .offset_i(offs), .literal_i(lit), .src_full_i(src), .write_en_i(wen), .wdata_i(wdata),
      .ext_set_i(ext), .usb_en_i(usb_en), .usb_addr_i(usb_addr), .usb_we_i(usb_we),
      .usb_wdata_i(usb_wdata), .usb_rdata_o(usb_rdata), .phase_o(phase),
      .bank_pointer_o(bp), .addr_o(addr), .rdata_o(rdata), .rdata_valid_o(rdv),
      .flags_upd_o(flags), .is_nop_o(nop), .dest_full_o(dest));
   // ----------------------------------------
   // Checking and expectations
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] off);
      logic [7:0] split;
      split = ext ? dmb_pkg::ACCESS_SPLIT_EXT : dmb_pkg::ACCESS_SPLIT;
      if (a) return {cur_bp, off};
      return (off < split) ? {dmb_pkg::ACCESS_LOW_BANK, off} : {dmb_pkg::ACCESS_HIGH_BANK, off};
   endfunction : exp_addr
   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   // One slot: wait for Q1, then watch four edges for the pulses
   task automatic run(input logic [1:0] o, input logic a, input logic [7:0] off,
      input logic [7:0] l, input logic [11:0] fa, input logic [15:0] iw, input logic sk,
      input logic w, input logic [7:0] wd);
      int n;
      n = 0;
      op <= o; acc <= a; offs <= off; lit <= l; src <= fa; instr <= iw; skp <= sk;
      wr <= w; wdata <= wd; issue <= 1'b1;
      #1;
      while (phase !== 2'h0) begin
         @(posedge clk_i);
         #1;
         n++;
         if (n > 8) begin
            fails++;
            test_done();
         end
      end
      @(posedge clk_i);
      issue <= 1'b0;
      nrd = 0; nfl = 0; nnop = 0;
      for (int k = 0; k < 4; k++) begin
         if (k > 0) @(posedge clk_i);
         #1;
         if (rdv === 1'b1) begin
            nrd++;
            got = rdata;
         end
         if (flags === 1'b1) nfl++;
         if (nop === 1'b1) nnop++;
      end
   endtask : run
   task automatic lbank(input logic [7:0] l);
      run(2'h3, 1'b0, 8'h00, l, 12'h000, 16'h0000, 1'b0, 1'b0, 8'h00);
      cur_bp = l[3:0];
      chk("bank_pointer", {8'h00, 4'h0, l[3:0]}, {8'h00, bp});
   endtask : lbank
   task automatic data(input logic a, input logic [7:0] off, input logic w, input logic [7:0] wd);
      logic [11:0] ea;
      run(2'h1, a, off, 8'h00, 12'h000, 16'h0000, 1'b0, w, wd);
      // Expected address worked out only once the extended-set input has settled
      ea = exp_addr(a, off);
      chk("addr", {4'h0, ea}, {4'h0, addr});
      chk("flags", 16'(w), 16'(nfl));
      chk("reads", 16'h0001, 16'(nrd));
      if (!IMPL[ea[11:8]]) begin
         chk("unimpl", 16'h0000, {8'h00, got});
      end else if (known[ea]) begin
         chk("rdata", {8'h00, mem[ea]}, {8'h00, got});
      end
      if (w && IMPL[ea[11:8]]) begin
         mem[ea] = wd;
         known[ea] = 1'b1;
      end
   endtask : data
   task automatic usb_acc(input logic [11:0] a, input logic we, input logic [7:0] wd);
      usb_addr <= a; usb_we <= we; usb_wdata <= wd;
      @(posedge clk_i);
      usb_we <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask : usb_acc
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      rst_n_i = 1'b0; issue = 1'b0; wr = 1'b0; skp = 1'b0; acc = 1'b0; ext = 1'b0;
      usb_en = 1'b0; usb_we = 1'b0; op = 2'h0; instr = 16'h0000; offs = 8'h00; lit = 8'h00;
      wdata = 8'h00; usb_wdata = 8'h00; src = 12'h000; usb_addr = 12'h000; cur_bp = 4'h0;
      void'($urandom(32'hB119));
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("bank_reset", 16'h0000, {8'h00, bp});
      lbank(8'hFF);
      lbank(8'h02);
      data(1'b1, 8'h10, 1'b1, 8'hA5);
      data(1'b1, 8'h10, 1'b0, 8'h00);
      lbank(8'h07);
      data(1'b1, 8'h33, 1'b1, 8'h5A);
      data(1'b1, 8'h33, 1'b0, 8'h00);
      data(1'b0, 8'h5F, 1'b1, 8'h11);
      data(1'b0, 8'h60, 1'b1, 8'h22);
      data(1'b0, 8'h5F, 1'b0, 8'h00);
      data(1'b0, 8'h60, 1'b0, 8'h00);
      // Bank pointer is 7 here, so a banked fetch would read zero
      run(2'h2, 1'b0, 8'h00, 8'h00, 12'h210, 16'h0000, 1'b0, 1'b0, 8'h00);
      run(2'h0, 1'b0, 8'h00, 8'h00, 12'h000, 16'hF345, 1'b0, 1'b0, 8'h00);
      chk("move_src", {8'h00, mem[12'h210]}, {8'h00, got});
      chk("move_dest", 16'h0345, {4'h0, dest});
      chk("pair_nop", 16'h0000, 16'(nnop));
      run(2'h0, 1'b0, 8'h00, 8'h00, 12'h000, 16'hF456, 1'b1, 1'b0, 8'h00);
      chk("lone_nop", 16'h0001, 16'(nnop));
      usb_en <= 1'b1;
      usb_acc(12'h1AB, 1'b1, 8'hC3);
      mem[12'h1AB] = 8'hC3;
      known[12'h1AB] = 1'b1;
      lbank(8'h01);
      data(1'b1, 8'hAB, 1'b0, 8'h00);
      lbank(8'h02);
      data(1'b1, 8'h20, 1'b1, 8'h3C);
      usb_acc(12'h220, 1'b0, 8'h00);
      chk("usb_rdata", 16'h003C, {8'h00, usb_rdata});
      usb_en <= 1'b0;
      usb_acc(12'h220, 1'b0, 8'h00);
      chk("usb_off", 16'h0000, {8'h00, usb_rdata});
      for (int i = 0; i < 80; i++) begin
         r = $urandom;
         ext <= r[3];
         if (r[0]) lbank(r[15:8]);
         else data(r[1], r[15:8], r[2], r[23:16]);
      end
      test_done();
   end
endmodule : data_memory_bank_addressing_bench
